// *** core/byte_store.sv ***
/*
 static byte store with one write port and one combinational read port.
 assumes the owner decodes mapping and gives one access per cycle.
*/
`timescale 1ns/1ps
module byte_store #(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned IDX_W = 6
) (
   input  wire logic             clock,
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [7:0]       wr_data,
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [7:0]       rd_data
);
   // no reset on the cells: static storage keeps content, reset clears nothing
   logic [7:0] cells [DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         cells[wr_idx] <= wr_data;
      end
   end

   assign rd_data = cells[rd_idx];
endmodule

// *** core/data_mem_pkg.sv ***
/*
 data memory map constants: bank size, region boundaries, pointer and bank field layout.
 assumes a core data path that issues one byte access per cycle.
*/
package data_mem_pkg;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned ADDR_W       = 7;
   localparam int unsigned BANK_SEL_W   = 2;
   localparam logic [6:0]  BANK_LAST    = 7'h7F;
   localparam logic [6:0]  SFS_BASE     = 7'h00;
   localparam logic [6:0]  SFS_LAST     = 7'h3F;
   localparam logic [6:0]  GPS_BASE     = 7'h40;
   localparam int unsigned GPS_DEPTH    = 64;
   localparam int unsigned GPS_IDX_W    = 6;
   localparam int unsigned SFS_DEPTH    = 64;
   localparam logic [1:0]  BANK_ZERO    = 2'h0;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [5:0]  IDX_ZERO     = 6'h00;
   localparam logic [6:0]  ADDR_ZERO    = 7'h00;
   // bank select field position inside the status byte
   localparam int unsigned BANK_SEL_LSB = 5;
   // special locations implemented by this store, others are unmapped
   localparam logic [63:0] SFS_IMPL_MASK = 64'h0000_0000_0000_FFFF;
endpackage

// *** core/data_memory_bank_map.sv ***
/*
 single-bank data memory map: special function storage low, general purpose storage high,
 direct or pointer-based addressing, bank select field held in a status byte.
 assumes the core presents one access per cycle; read data returns two cycles later.
*/
// Operation
// - one bank holds both the special function storage and the general purpose storage.
// - a two-bit bank select field in the status byte picks the bank, and only zero exists.
// - the bank spans addresses zero through 7Fh, 128 byte locations.
// - the lowest addresses belong to the special function storage.
// - general purpose storage sits above the special region and is static RAM.
// - general purpose storage holds sixty-four eight-bit entries.
// - each general purpose entry is reachable directly or through the indirect pointer register.
// - special function locations 00h through 0Fh are static RAM cells that keep their values; 10h through 3Fh are unmapped and read as zero.
`timescale 1ns/1ps
module data_memory_bank_map
   import data_mem_pkg::*;
(
   input  wire logic                           clock,
   input  wire logic                           rst_n,
   input  wire logic                           access_en,
   input  wire logic                           write_en,
   input  wire logic                           indirect,
   input  wire logic [data_mem_pkg::ADDR_W-1:0] direct_addr,
   input  wire logic [data_mem_pkg::DATA_W-1:0] write_data,
   input  wire logic                           ptr_load,
   input  wire logic [data_mem_pkg::DATA_W-1:0] ptr_data,
   input  wire logic                           status_load,
   input  wire logic [data_mem_pkg::DATA_W-1:0] status_data,
   output logic      [data_mem_pkg::DATA_W-1:0] read_data,
   output logic                                read_valid,
   output logic      [data_mem_pkg::DATA_W-1:0] indirect_pointer_register,
   output logic      [data_mem_pkg::BANK_SEL_W-1:0] bank_select_field
);
   import data_mem_pkg::*;

   logic [7:0] ptr_r, ptr_nxt;
   logic [1:0] bank_r, bank_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       rvalid_r, rvalid_nxt;
   logic       rd_sfs_r, rd_sfs_nxt;
   logic       rd_gps_r, rd_gps_nxt;
   logic [6:0] eff_addr;
   logic       bank_ok, in_sfs, in_gps, sfs_impl;
   logic       gps_we, sfs_we;
   logic [5:0] gps_idx, sfs_idx;
   logic [7:0] gps_rd, sfs_rd;

   always_comb begin
      // pointer's top bit lies beyond the 128-byte bank and is dropped
      eff_addr = indirect ? ptr_r[ADDR_W-1:0] : direct_addr;
      bank_ok  = (bank_r == BANK_ZERO);
      in_sfs   = (eff_addr <= SFS_LAST);
      in_gps   = (eff_addr >= GPS_BASE) && (eff_addr <= BANK_LAST);
      sfs_idx  = eff_addr[GPS_IDX_W-1:0];
      gps_idx  = GPS_IDX_W'(eff_addr - GPS_BASE);
      sfs_impl = SFS_IMPL_MASK[sfs_idx];
      sfs_we   = access_en && write_en && bank_ok && in_sfs && sfs_impl;
      gps_we   = access_en && write_en && bank_ok && in_gps;
   end

   always_comb begin
      ptr_nxt    = ptr_load ? ptr_data : ptr_r;
      bank_nxt   = status_load ? status_data[BANK_SEL_LSB +: BANK_SEL_W] : bank_r;
      rvalid_nxt = access_en && !write_en;
      rd_sfs_nxt = rvalid_nxt && bank_ok && in_sfs && sfs_impl;
      rd_gps_nxt = rvalid_nxt && bank_ok && in_gps;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ptr_r    <= BYTE_ZERO;
         bank_r   <= BANK_ZERO;
         rvalid_r <= 1'b0;
         rd_sfs_r <= 1'b0;
         rd_gps_r <= 1'b0;
      end else begin
         ptr_r    <= ptr_nxt;
         bank_r   <= bank_nxt;
         rvalid_r <= rvalid_nxt;
         rd_sfs_r <= rd_sfs_nxt;
         rd_gps_r <= rd_gps_nxt;
      end
   end

   // read index captured with the request so stores answer the next cycle
   logic [5:0] sfs_ridx_r, gps_ridx_r;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sfs_ridx_r <= IDX_ZERO;
         gps_ridx_r <= IDX_ZERO;
      end else if (access_en) begin
         sfs_ridx_r <= sfs_idx;
         gps_ridx_r <= gps_idx;
      end
   end

   byte_store #(.DEPTH(SFS_DEPTH), .IDX_W(GPS_IDX_W)) sfs_store (
      .clock   (clock),
      .wr_en   (sfs_we),
      .wr_idx  (sfs_idx),
      .wr_data (write_data),
      .rd_idx  (sfs_ridx_r),
      .rd_data (sfs_rd)
   );

   byte_store #(.DEPTH(GPS_DEPTH), .IDX_W(GPS_IDX_W)) gps_store (
      .clock   (clock),
      .wr_en   (gps_we),
      .wr_idx  (gps_idx),
      .wr_data (write_data),
      .rd_idx  (gps_ridx_r),
      .rd_data (gps_rd)
   );

   // registered output mux keeps every top output straight from a flip-flop,
   // at the cost of a second cycle of read latency
   always_comb begin
      rdata_nxt = BYTE_ZERO;
      if (rd_sfs_r) begin
         rdata_nxt = sfs_rd;
      end else if (rd_gps_r) begin
         rdata_nxt = gps_rd;
      end
   end

   logic valid_out_r;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_r     <= BYTE_ZERO;
         valid_out_r <= 1'b0;
      end else begin
         rdata_r     <= rdata_nxt;
         valid_out_r <= rvalid_r;
      end
   end

   assign read_data                 = rdata_r;
   assign read_valid                = valid_out_r;
   assign indirect_pointer_register = ptr_r;
   assign bank_select_field         = bank_r;
endmodule

// *** testbench/core_model.sv ***
/* core data path model: one byte access per call, driven at the falling edge.
 assumes the bench calls it one access at a time. */
`timescale 1ns/1ps
module core_model (
   input  wire logic       clock,
   output logic            access_en,
   output logic            write_en,
   output logic            indirect,
   output logic      [6:0] direct_addr,
   output logic      [7:0] write_data
);
   initial {access_en, write_en, indirect, direct_addr, write_data} = '0;
   task automatic acc(logic w, logic i, logic [6:0] a, logic [7:0] d);
      {access_en, write_en, indirect, direct_addr, write_data} = {1'b1, w, i, a, d};
      @(negedge clock);
   endtask
   // released address and data lines show the inverse so stale values cannot pass for good ones
   task automatic idle();
      {access_en, direct_addr, write_data} = {1'b0, ~direct_addr, ~write_data};
      @(negedge clock);
   endtask
endmodule

// *** testbench/data_memory_bank_map_tb_top.sv ***
/* bench for the bank map with core model and bound checker.
 assumes read data shows one edge after the taking edge. */
`timescale 1ns/1ps
module data_memory_bank_map_tb_top;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic       access_en, write_en, indirect, ptr_load, status_load, read_valid;
   logic [6:0] direct_addr;
   logic [7:0] write_data, ptr_data, status_data, read_data, indirect_pointer_register;
   logic [1:0] bank_select_field;
   int         error_cnt = 0;
   int         tests_run = 0;
   always #5 clock = ~clock;
   core_model u_core (.*);
   data_memory_bank_map DUT (.*);
   task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic rd(logic i, logic [6:0] a, logic [7:0] exp);
      u_core.acc(1'b0, i, a, exp);
      u_core.idle();
      chk("valid", {7'h00, read_valid}, 8'h01);
      chk("data", read_data, exp);
   endtask
   task automatic t_gps();
      for (int k = 0; k < 64; k++) begin
         u_core.acc(1'b1, 1'b0, 7'h40 + 7'(k), 8'(k) ^ 8'hA5);
         rd(1'b0, 7'h40 + 7'(k), 8'(k) ^ 8'hA5);
      end
      for (int k = 0; k < 64; k++) begin
         ptr_load = 1'b1;
         ptr_data = {1'b1, 7'h40 + 7'(k)};
         @(negedge clock);
         ptr_load = 1'b0;
         chk("ptr", indirect_pointer_register, ptr_data);
         u_core.acc(1'b1, 1'b1, 7'h00, 8'(k) ^ 8'h5A);
         rd(1'b0, 7'h40 + 7'(k), 8'(k) ^ 8'h5A);
      end
      rd(1'b1, 7'h00, 8'h65);
   endtask
   task automatic t_sfs();
      for (int a = 0; a < 32; a++) begin
         u_core.acc(1'b1, 1'b0, 7'(a), 8'hC0 | 8'(a));
         rd(1'b0, 7'(a), (a < 16) ? (8'hC0 | 8'(a)) : 8'h00);
      end
   endtask
   task automatic t_bank();
      for (int b = 1; b < 5; b++) begin
         status_load = 1'b1;
         status_data = (b < 4) ? 8'(b << 5) : 8'h9F;
         @(negedge clock);
         status_load = 1'b0;
         chk("bank", {6'h00, bank_select_field}, (b < 4) ? 8'(b) : 8'h00);
         if (b < 4) u_core.acc(1'b1, 1'b0, 7'h40, 8'h3C);
         rd(1'b0, 7'h40, (b < 4) ? 8'h00 : 8'h5A);
      end
   endtask
   // mid-run reset: outputs clear, the cells keep what was written
   task automatic t_reset();
      u_core.idle();
      chk("valid end", {7'h00, read_valid}, 8'h00);
      chk("data end", read_data, 8'h00);
      rst_n = 1'b0;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      chk("ptr rst", indirect_pointer_register, 8'h00);
      chk("bank rst", {6'h00, bank_select_field}, 8'h00);
      chk("valid rst", {7'h00, read_valid}, 8'h00);
      rd(1'b1, 7'h00, 8'hC0);
      rd(1'b0, 7'h40, 8'h5A);
   endtask
   initial begin
      {ptr_load, ptr_data, status_load, status_data} = '0;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      t_gps();
      t_sfs();
      t_bank();
      t_reset();
      end_of_test();
   end
   initial begin
      #100000;
      error_cnt++;
      end_of_test();
   end
endmodule

// *** testbench/map_checker.sv ***
/* port checker for the bank map.
 assumes it is bound onto the map top. */
`timescale 1ns/1ps
module map_checker (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       access_en,
   input wire logic       write_en,
   input wire logic       indirect,
   input wire logic [6:0] direct_addr,
   input wire logic [7:0] write_data,
   input wire logic       ptr_load,
   input wire logic [7:0] ptr_data,
   input wire logic       status_load,
   input wire logic [7:0] status_data,
   input wire logic [7:0] read_data,
   input wire logic       read_valid,
   input wire logic [7:0] indirect_pointer_register,
   input wire logic [1:0] bank_select_field
);
   logic       rd_req;
   logic [1:0] sel_in;
   assign rd_req = access_en && !write_en;
   assign sel_in = status_data[6:5];
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence wr_s;
      access_en && write_en && !indirect && direct_addr[6] && bank_select_field == 2'h0;
   endsequence
   sequence rd_same_s;
      rd_req && !indirect && $stable(direct_addr) && $stable(write_data);
   endsequence
   chk_read_lat: assert property (rd_req |-> ##2 read_valid) else $error("late");
   chk_no_stray: assert property (read_valid |-> $past(rd_req, 2)) else $error("stray");
   chk_idle_zero: assert property (!read_valid |-> read_data == 8'h00) else $error("idle");
   chk_bank_load:
      assert property (status_load |=> bank_select_field == $past(sel_in)) else $error("bank");
   chk_ptr_load:
      assert property (ptr_load |=> indirect_pointer_register == $past(ptr_data)) else $error("ptr");
   chk_bank_off:
      assert property (rd_req && bank_select_field != 2'h0 |-> ##2 read_data == 8'h00)
      else $error("bank off");
   chk_sfs_hole:
      assert property (rd_req && !indirect && direct_addr inside {[7'h10:7'h3F]}
         |-> ##2 read_data == 8'h00) else $error("hole");
   chk_readback:
      assert property (wr_s ##1 rd_same_s |-> ##2 read_data == $past(write_data, 2))
      else $error("readback");
endmodule
bind data_memory_bank_map map_checker u_chk (.*);
